// ---- led_driver_diag_status.sv ----
// Functional notes
// R1 - temperature register reads signed degree code
// R2 - host uses overtemp flag for out-of-range codes
// R3 - recharge boot cap when switch idle
// R4 - charge compensation gated by driver, dim low, no boot undervoltage, no low headroom
// R5 - status layout: seven flags, bit 2 zero
// R6 - supply-good follows input above undervoltage threshold
// R7 - supply good lets gates switch per dim
// R8 - supply low stops gate supply and measuring
// R9 - fault needs supply good; measure needs both
// R10 - command error on bad write, read, count
// R11 - erroneous write discarded; host discards bad read
// R12 - writing status register clears command error
// R13 - after error answer status then second register
// R14 - overtemp shuts gate, faults if supply was good
// R15 - clear request clears overtemp and its fault
// R16 - gate supply fault after startup or running delay
// R17 - fault stops measuring and output current
// R18 - fault cleared by request, off mode, reset
// R19 - current-hit shows previous dimming cycle result
// R20 - clear request self-clears once errors cleared
// R21 - current-hit updates at dim fall or copy request
// R22 - all flags zero after reset
`default_nettype none
module led_driver_diag_status #(
  parameter int unsigned ERR_STARTUP_CYCLES = led_diag_pkg::ERR_STARTUP_CYCLES,
  parameter int unsigned ERR_OPER_CYCLES = led_diag_pkg::ERR_OPER_CYCLES,
  parameter int unsigned MEAS_CYCLES = led_diag_pkg::LED_MEAS_CYCLES
) (
  input wire logic mclk, // core clock, 125 MHz
  input wire logic resetn, // power-on reset, async, active low
  input wire logic spiClk, // serial clock from the host, sampled
  input wire logic spiSelN, // serial select, active low
  input wire logic spiMosi, // serial data from the host
  output logic spiMiso, // serial data to the host
  output logic spiMisoOe, // miso drive enable, high while selected
  input wire logic enableIn, // device enable, low means off mode
  input wire logic vinAboveUv, // input voltage above undervoltage threshold
  input wire logic dieOverTemp, // die above shutdown temperature
  input wire logic gateSupplyAtTarget, // gate supply regulated to target
  input wire logic [7:0] dieTempCode, // measured die temperature code
  input wire logic [1:0] dimIn, // per-channel dimming inputs
  input wire logic [1:0] currentReached, // per-channel target current reached
  input wire logic [1:0] bootUv, // per-channel bootstrap undervoltage
  input wire logic [1:0] lowHeadroom, // per-channel low headroom
  input wire logic [1:0] switchToggling, // per-channel switch node toggling
  output logic gateRegEn, // gate supply regulator enable
  output logic gateDriverEn, // gate driver enable
  output logic [1:0] gateSwitchEn, // per-channel gate switching and current
  output logic ledMeasureUpdate, // led voltage registers may update
  output logic [1:0] bootRechargeReq, // per-channel bootstrap recharge
  output logic [1:0] chargeMaintainEn // per-channel charge compensation
);
  localparam int TW = $clog2(ERR_STARTUP_CYCLES + 1);

  if (ERR_OPER_CYCLES < 2 || ERR_STARTUP_CYCLES < ERR_OPER_CYCLES) begin : g_bad_delay
    $error("error delays must be at least two and startup not below running");
  end

  // ---------------- serial port ----------------
  logic sclkPrev;
  logic selPrev;
  logic [3:0] bitCount;
  logic wordSeen;
  logic [15:0] rxShift;
  logic [15:0] cmdWord;
  logic [7:0] txFirst;
  logic [7:0] txSecond;
  logic misoBit;
  logic errShow;

  // ---------------- register state ----------------
  logic supplyGoodFlag;
  logic spiErr;
  logic overtempFlag;
  logic gateSupplyFault;
  logic gateSupplyGood;
  logic clrReq;
  logic [1:0] dimEnable;
  logic [1:0] copyReq;
  logic [7:0] dieTemp;
  led_diag_pkg::gate_phase_t phase;
  led_diag_pkg::gate_phase_t next_phase;

  logic [1:0] chCurrentHit;
  logic [1:0] chToggled;

  wire sclkRise = spiClk & ~sclkPrev & ~spiSelN;
  wire sclkFall = ~spiClk & sclkPrev & ~spiSelN;
  wire frameStart = ~spiSelN & selPrev;
  wire frameEnd = spiSelN & ~selPrev;
  wire [15:0] nextRx = {rxShift[14:0], spiMosi};
  wire [6:0] earlyAddr = nextRx[6:0];

  wire cmdWrite = cmdWord[led_diag_pkg::CMD_WRITE_BIT];
  wire [6:0] cmdAddr = cmdWord[led_diag_pkg::CMD_ADDR_MSB:led_diag_pkg::CMD_ADDR_LSB];
  wire [7:0] cmdData = cmdWord[7:0];

  wire hitFunc = (cmdAddr == led_diag_pkg::ADDR_FUNC_CTRL);
  wire hitCopy = (cmdAddr == led_diag_pkg::ADDR_COPY_REQ);
  wire hitTemp = (cmdAddr == led_diag_pkg::ADDR_DIE_TEMP);
  wire hitDiagTwo = (cmdAddr == led_diag_pkg::ADDR_DIAG_TWO);
  wire hitDiagOne = (cmdAddr == led_diag_pkg::ADDR_DIAG_ONE);
  wire addrWritable = hitFunc | hitCopy | hitDiagTwo | hitDiagOne;
  wire addrKnown = addrWritable | hitTemp;

  // a select with no clocks at all is ignored rather than flagged
  wire countBad = (bitCount != 4'h0); // see R10
  wire badAccess = wordSeen & (cmdWrite ? ~addrWritable : ~addrKnown); // see R10
  wire frameErr = frameEnd & (countBad | badAccess);
  // only clean whole-word writes reach the registers
  wire wrStrobe = frameEnd & wordSeen & ~countBad & cmdWrite & addrWritable; // see R11
  wire wrFunc = wrStrobe & hitFunc;
  wire wrCopy = wrStrobe & hitCopy;
  wire wrDiagTwo = wrStrobe & hitDiagTwo;
  wire wrDiagOne = wrStrobe & hitDiagOne;

  // ---------------- register images ----------------
  logic [7:0] diagOne;
  always_comb begin
    diagOne = 8'h00; // see R5
    diagOne[led_diag_pkg::DS_SUPPLY_GOOD] = supplyGoodFlag;
    diagOne[led_diag_pkg::DS_CMD_ERR] = spiErr;
    diagOne[led_diag_pkg::DS_OVERTEMP] = overtempFlag;
    diagOne[led_diag_pkg::DS_GATE_FAULT] = gateSupplyFault;
    diagOne[led_diag_pkg::DS_GATE_GOOD] = gateSupplyGood;
    diagOne[led_diag_pkg::DS_CH2_HIT] = chCurrentHit[1];
    diagOne[led_diag_pkg::DS_CH1_HIT] = chCurrentHit[0];
  end

  logic [7:0] funcCtrl;
  always_comb begin
    funcCtrl = 8'h00;
    funcCtrl[led_diag_pkg::FC_STATUS] = 1'b1;
    funcCtrl[led_diag_pkg::FC_CLEAR] = clrReq;
    funcCtrl[led_diag_pkg::FC_DIM_EN2] = dimEnable[1];
    funcCtrl[led_diag_pkg::FC_DIM_EN1] = dimEnable[0];
  end

  wire [7:0] diagTwo = led_diag_pkg::DIAG_TWO_FIXED | {6'h00, chToggled};

  logic [7:0] readData;
  always_comb begin
    case (earlyAddr)
      led_diag_pkg::ADDR_FUNC_CTRL: readData = funcCtrl;
      led_diag_pkg::ADDR_COPY_REQ: readData = {6'h00, copyReq};
      led_diag_pkg::ADDR_DIE_TEMP: readData = dieTemp; // see R1
      led_diag_pkg::ADDR_DIAG_TWO: readData = diagTwo;
      led_diag_pkg::ADDR_DIAG_ONE: readData = diagOne;
      default: readData = diagOne;
    endcase
  end

  // ---------------- serial shifting ----------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclkPrev <= 1'b0;
      selPrev <= 1'b1;
    end else begin
      sclkPrev <= spiClk;
      selPrev <= spiSelN;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bitCount <= 4'h0;
      wordSeen <= 1'b0;
      rxShift <= 16'h0000;
      cmdWord <= 16'h0000;
    end else if (frameStart) begin
      bitCount <= 4'h0;
      wordSeen <= 1'b0;
    end else if (sclkRise) begin
      rxShift <= nextRx;
      bitCount <= bitCount + 4'h1;
      if (bitCount == 4'hF) begin
        cmdWord <= nextRx;
        wordSeen <= 1'b1;
      end
    end
  end

  // first byte is always the status image, second the addressed data, or diagnostic two after an error
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txFirst <= 8'h00;
      txSecond <= 8'h00;
      misoBit <= 1'b0;
    end else if (frameStart) begin
      txFirst <= diagOne; // see R13
      misoBit <= diagOne[7];
    end else if (sclkRise && bitCount == 4'h7) begin
      txSecond <= errShow ? diagTwo : readData; // see R13
    end else if (sclkFall) begin
      misoBit <= bitCount[3] ? txSecond[~bitCount[2:0]] : txFirst[~bitCount[2:0]];
    end
  end

  // error answer is owed to the next access only, then dropped
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      errShow <= 1'b0;
    end else begin
      errShow <= frameErr | (errShow & ~(sclkRise && bitCount == 4'h7)); // see R13
    end
  end

  assign spiMiso = misoBit;
  assign spiMisoOe = ~spiSelN;

  // ---------------- control registers ----------------
  wire anyErr = overtempFlag | gateSupplyFault;
  wire clearNow = clrReq & anyErr; // see R15, R18

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clrReq <= 1'b0;
      dimEnable <= led_diag_pkg::FUNC_CTRL_RESET[led_diag_pkg::FC_DIM_EN2:led_diag_pkg::FC_DIM_EN1];
    end else if (wrFunc) begin
      clrReq <= cmdData[led_diag_pkg::FC_CLEAR];
      dimEnable <= cmdData[led_diag_pkg::FC_DIM_EN2:led_diag_pkg::FC_DIM_EN1];
    end else if (clearNow) begin
      clrReq <= 1'b0; // see R20
    end
  end

  // copy requests live for one cycle, which is the whole update
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      copyReq <= 2'h0;
    end else begin
      copyReq <= wrCopy ? cmdData[1:0] : 2'h0; // see R21
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dieTemp <= 8'h00;
    end else begin
      dieTemp <= dieTempCode; // see R1
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      spiErr <= 1'b0; // see R22
    end else begin
      spiErr <= frameErr | (spiErr & ~wrDiagOne); // see R10, R12
    end
  end

  // ---------------- supply and fault flags ----------------
  wire otSet = dieOverTemp & ~overtempFlag;
  wire faultByOt = otSet & gateSupplyGood & supplyGoodFlag & enableIn; // see R14, R9
  wire faultByTimer;
  wire [TW-1:0] errLimit = (phase == led_diag_pkg::PHASE_RUNNING) ?
                           TW'(ERR_OPER_CYCLES) : TW'(ERR_STARTUP_CYCLES);

  assign gateRegEn = enableIn & supplyGoodFlag & ~gateSupplyFault & ~overtempFlag; // see R8, R14
  assign gateDriverEn = gateRegEn & gateSupplyGood; // see R16
  assign gateSwitchEn = {2{gateDriverEn}} & dimIn & dimEnable; // see R7, R17
  assign ledMeasureUpdate = supplyGoodFlag & gateSupplyGood & ~gateSupplyFault; // see R9, R17

  err_delay_timer #(
    .WIDTH(TW)
  ) u_err_delay (
    .mclk(mclk),
    .resetn(resetn),
    .run(gateRegEn & ~gateSupplyAtTarget), // see R16
    .limit(errLimit),
    .expired(faultByTimer)
  );

  always_comb begin
    case (phase)
      led_diag_pkg::PHASE_STARTUP:
        next_phase = (gateRegEn & gateSupplyGood) ? led_diag_pkg::PHASE_RUNNING : phase;
      led_diag_pkg::PHASE_RUNNING:
        next_phase = gateRegEn ? phase : led_diag_pkg::PHASE_STARTUP;
      default:
        next_phase = led_diag_pkg::PHASE_STARTUP;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase <= led_diag_pkg::PHASE_STARTUP;
      supplyGoodFlag <= 1'b0;
      overtempFlag <= 1'b0;
      gateSupplyGood <= 1'b0;
      gateSupplyFault <= 1'b0; // see R18, R22
    end else begin
      phase <= next_phase;
      supplyGoodFlag <= vinAboveUv; // see R6
      overtempFlag <= dieOverTemp | (overtempFlag & ~clearNow); // see R14, R15
      gateSupplyGood <= gateRegEn & gateSupplyAtTarget & ~dieOverTemp; // see R8, R14
      // a fault raised now beats a clear in the same cycle
      gateSupplyFault <= faultByOt | faultByTimer |
                         (gateSupplyFault & ~clearNow & enableIn); // see R16, R18, R8
    end
  end

  // ---------------- channels ----------------
  chan_if chLink [2] ();

  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign chLink[i].dim = dimIn[i];
    assign chLink[i].reached = currentReached[i];
    assign chLink[i].bootUv = bootUv[i];
    assign chLink[i].lowHeadroom = lowHeadroom[i];
    assign chLink[i].switchToggling = switchToggling[i];
    assign chLink[i].supplyGood = supplyGoodFlag;
    assign chLink[i].gateDriverEn = gateDriverEn; // see R4
    assign chLink[i].copyReq = copyReq[i];
    assign chLink[i].toggleClr = wrDiagTwo;
    assign chCurrentHit[i] = chLink[i].currentHit;
    assign chToggled[i] = chLink[i].toggled;
    assign bootRechargeReq[i] = chLink[i].rechargeReq; // see R3
    assign chargeMaintainEn[i] = chLink[i].maintainEn;

    chan_diag #(
      .MEAS_CYCLES(MEAS_CYCLES)
    ) u_chan (
      .mclk(mclk),
      .resetn(resetn),
      .ch(chLink[i])
    );
  end
endmodule
`default_nettype wire

// ---- led_diag_pkg.sv ----
`default_nettype none
package led_diag_pkg;
  // register map, byte address carried in the 7-bit command field
  localparam logic [6:0] ADDR_FUNC_CTRL = 7'h00;
  localparam logic [6:0] ADDR_COPY_REQ = 7'h06;
  localparam logic [6:0] ADDR_DIE_TEMP = 7'h26;
  localparam logic [6:0] ADDR_DIAG_TWO = 7'h36;
  localparam logic [6:0] ADDR_DIAG_ONE = 7'h37;

  // diagnostic status one field positions
  localparam int DS_SUPPLY_GOOD = 7;
  localparam int DS_CMD_ERR = 6;
  localparam int DS_OVERTEMP = 5;
  localparam int DS_GATE_FAULT = 4;
  localparam int DS_GATE_GOOD = 3;
  localparam int DS_CH2_HIT = 1;
  localparam int DS_CH1_HIT = 0;

  // function control field positions and reset value
  localparam int FC_STATUS = 7;
  localparam int FC_CLEAR = 6;
  localparam int FC_DIM_EN2 = 2;
  localparam int FC_DIM_EN1 = 1;
  localparam logic [7:0] FUNC_CTRL_RESET = 8'h06;

  // diagnostic two: bit 6 is a reserved bit that reads as one
  localparam logic [7:0] DIAG_TWO_FIXED = 8'h40;

  // signed degree code limits of the die temperature register
  localparam logic [7:0] TEMP_CODE_MIN = 8'hD8;
  localparam logic [7:0] TEMP_CODE_MAX = 8'hAF;

  // serial frame layout: write flag, address, data; msb first
  localparam int FRAME_BITS = 16;
  localparam int CMD_WRITE_BIT = 15;
  localparam int CMD_ADDR_MSB = 14;
  localparam int CMD_ADDR_LSB = 8;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_ERR_STARTUP_US = 1000;
  localparam int unsigned T_ERR_OPER_US = 100;
  localparam int unsigned T_LED_MEAS_US = 500;
  localparam int unsigned ERR_STARTUP_CYCLES =
    (T_ERR_STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERR_OPER_CYCLES =
    (T_ERR_OPER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LED_MEAS_CYCLES =
    (T_LED_MEAS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {PHASE_STARTUP, PHASE_RUNNING} gate_phase_t;
endpackage
`default_nettype wire

// ---- chan_if.sv ----
`default_nettype none
interface chan_if;
  logic dim;
  logic reached;
  logic bootUv;
  logic lowHeadroom;
  logic switchToggling;
  logic supplyGood;
  logic gateDriverEn;
  logic copyReq;
  logic toggleClr;
  logic currentHit;
  logic toggled;
  logic rechargeReq;
  logic maintainEn;

  modport core (
    output dim, reached, bootUv, lowHeadroom, switchToggling,
    output supplyGood, gateDriverEn, copyReq, toggleClr,
    input currentHit, toggled, rechargeReq, maintainEn
  );
  modport lane (
    input dim, reached, bootUv, lowHeadroom, switchToggling,
    input supplyGood, gateDriverEn, copyReq, toggleClr,
    output currentHit, toggled, rechargeReq, maintainEn
  );
endinterface
`default_nettype wire

// ---- err_delay_timer.sv ----
`default_nettype none
module err_delay_timer #(
  parameter int WIDTH = 17
) (
  input wire logic mclk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic run, // count while high, restart when low
  input wire logic [WIDTH-1:0] limit, // cycles until expiry
  output logic expired // high in the cycle the limit is reached
);
  logic [WIDTH-1:0] count;

  if (WIDTH < 2) begin : g_bad_width
    $error("err_delay_timer WIDTH too small");
  end

  wire atLimit = (count == limit - WIDTH'(1));
  assign expired = run & atLimit;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (!run || atLimit) begin
      count <= '0;
    end else begin
      count <= count + WIDTH'(1);
    end
  end
endmodule
`default_nettype wire

// ---- chan_diag.sv ----
`default_nettype none
module chan_diag #(
  parameter int unsigned MEAS_CYCLES = led_diag_pkg::LED_MEAS_CYCLES
) (
  input wire logic mclk, // core clock
  input wire logic resetn, // async reset, active low
  chan_if.lane ch // per-channel signals to and from the core
);
  localparam int MW = $clog2(MEAS_CYCLES + 1);
  localparam logic [MW-1:0] MEAS_LIMIT = MW'(MEAS_CYCLES);

  if (MEAS_CYCLES < 1) begin : g_bad_meas
    $error("chan_diag MEAS_CYCLES must be at least one");
  end

  logic dimPrev;
  logic dimValid;
  logic cycleHit;
  logic [MW-1:0] lowCount;

  // no edge until dim has been sampled once, so a high idle level is no toggle
  wire dimFall = dimValid & dimPrev & ~ch.dim;
  wire dimEdge = dimValid & (dimPrev ^ ch.dim);
  wire lowLong = (lowCount == MEAS_LIMIT);
  // cycle flag: a new hit beats a simultaneous clear
  wire next_cycleHit = ch.reached | (cycleHit & ~(dimFall | ch.copyReq | ~ch.supplyGood));
  wire next_rechargeReq = ~ch.switchToggling & (lowLong | (ch.dim & ~cycleHit)); // see R3
  wire next_maintainEn = ch.gateDriverEn & ~ch.dim & ~ch.bootUv & ~ch.lowHeadroom; // see R4

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dimPrev <= 1'b0;
      dimValid <= 1'b0;
      cycleHit <= 1'b0;
      lowCount <= '0;
      ch.rechargeReq <= 1'b0;
      ch.maintainEn <= 1'b0;
    end else begin
      dimPrev <= ch.dim;
      dimValid <= 1'b1;
      cycleHit <= next_cycleHit;
      lowCount <= ch.dim ? '0 : (lowLong ? lowCount : lowCount + MW'(1));
      ch.rechargeReq <= next_rechargeReq;
      ch.maintainEn <= next_maintainEn;
    end
  end

  // previous-cycle result captured before the cycle flag is cleared
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ch.currentHit <= 1'b0; // see R22
    end else if (!ch.supplyGood || ch.lowHeadroom) begin
      ch.currentHit <= 1'b0;
    end else if (dimFall || ch.copyReq) begin
      ch.currentHit <= cycleHit; // see R19, R21
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ch.toggled <= 1'b0;
    end else begin
      ch.toggled <= dimEdge | (ch.toggled & ~ch.toggleClr);
    end
  end
endmodule
`default_nettype wire

// ---- led_diag_assertions.sv ----
`default_nettype none
module led_diag_checker #(
  parameter int unsigned ERR_STARTUP_CYCLES = 20
) (
  input wire logic mclk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic enableIn, // device enable
  input wire logic vinAboveUv, // supply above threshold
  input wire logic dieOverTemp, // die too hot
  input wire logic gateSupplyAtTarget, // gate supply regulated
  input wire logic [1:0] dimIn, // dimming inputs
  input wire logic [1:0] bootUv, // boot undervoltage
  input wire logic [1:0] lowHeadroom, // low headroom
  input wire logic [1:0] switchToggling, // switch node toggling
  input wire logic gateRegEn, // regulator enable
  input wire logic gateDriverEn, // driver enable
  input wire logic [1:0] gateSwitchEn, // gate switching
  input wire logic ledMeasureUpdate, // measurement update
  input wire logic [1:0] bootRechargeReq, // recharge request
  input wire logic [1:0] chargeMaintainEn // charge compensation
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // cycles the regulator has stayed on without reaching its target
  int unsigned stuck;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stuck <= 0;
    end else begin
      stuck <= (gateRegEn && !gateSupplyAtTarget) ? stuck + 1 : 0;
    end
  end
  a_maintain_gated: assert property (chargeMaintainEn ==
    $past({2{gateDriverEn}} & ~dimIn & ~bootUv & ~lowHeadroom))
    else $error("charge compensation enable wrong");
  a_recharge_idle: assert property ((bootRechargeReq & $past(switchToggling)) == 2'b00)
    else $error("recharge while switch toggles");
  a_switch_gated: assert property ((gateSwitchEn & ~({2{gateDriverEn}} & dimIn)) == 2'b00)
    else $error("gate switching without driver and dim");
  a_driver_needs_reg: assert property (gateDriverEn |-> gateRegEn)
    else $error("driver on with regulator off");
  a_reg_needs_vin: assert property (gateRegEn |-> $past(vinAboveUv))
    else $error("regulator on with supply low");
  a_measure_needs_vin: assert property (ledMeasureUpdate |-> $past(vinAboveUv))
    else $error("measurement update with supply low");
  a_overtemp_off: assert property (dieOverTemp |=> !gateRegEn)
    else $error("regulator on while over temperature");
  a_enable_off: assert property (!enableIn |-> !gateRegEn)
    else $error("regulator on in off mode");
  a_fault_bound: assert property (stuck <= ERR_STARTUP_CYCLES + 3)
    else $error("gate supply fault never raised");
  c_hot_running: cover property (dieOverTemp && gateDriverEn);
  c_maintain_one: cover property (chargeMaintainEn == 2'b10);
  c_fault_wait: cover property (stuck == 8);
endmodule

bind led_driver_diag_status led_diag_checker #(.ERR_STARTUP_CYCLES(ERR_STARTUP_CYCLES)) chk_u (
  .mclk(mclk), .resetn(resetn), .enableIn(enableIn), .vinAboveUv(vinAboveUv),
  .dieOverTemp(dieOverTemp), .gateSupplyAtTarget(gateSupplyAtTarget), .dimIn(dimIn),
  .bootUv(bootUv), .lowHeadroom(lowHeadroom), .switchToggling(switchToggling),
  .gateRegEn(gateRegEn), .gateDriverEn(gateDriverEn), .gateSwitchEn(gateSwitchEn),
  .ledMeasureUpdate(ledMeasureUpdate), .bootRechargeReq(bootRechargeReq),
  .chargeMaintainEn(chargeMaintainEn));
`default_nettype wire

// ---- spi_host_model.sv ----
`default_nettype none
module spi_host_model (
  input wire logic mclk, // core clock
  input wire logic spiMiso, // device data
  output logic spiClk, // serial clock, still outside frames
  output logic spiSelN, // select, active low
  output logic spiMosi // host data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spiClk = 1'b0;
    spiSelN = 1'b1;
    spiMosi = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // each level held over two mclk edges so the device sampler sees it
  task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    hold(1);
    spiSelN = 1'b0;
    hold(3);
    for (int i = 0; i < n; i++) begin
      spiMosi = w[15 - (i % 16)];
      r = {r[14:0], spiMiso};
      hold(2);
      spiClk = 1'b1;
      hold(2);
      spiClk = 1'b0;
      hold(3);
    end
    spiSelN = 1'b1;
    // released line must not keep the last bit
    spiMosi = ~spiMosi;
    hold(3);
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, resetn = 1'b0, enableIn = 1'b1, vinAboveUv = 1'b0, dieOverTemp = 1'b0;
  logic gateSupplyAtTarget = 1'b1, spiClk, spiSelN, spiMosi, spiMiso, spiMisoOe;
  logic gateRegEn, gateDriverEn, ledMeasureUpdate;
  logic [7:0] dieTempCode = 8'hD8;
  logic [1:0] dimIn = 2'b11, currentReached = 2'b00, bootUv = 2'b00, lowHeadroom = 2'b00;
  logic [1:0] switchToggling = 2'b00, gateSwitchEn, bootRechargeReq, chargeMaintainEn;
  logic [15:0] rsp;
  int fails = 0, samples_checked = 0;
  logic [16:0] bad [3] = '{{1'b1, 16'hA655}, {1'b1, 16'h1000}, {1'b0, 16'h8000}};

  led_driver_diag_status #(.ERR_STARTUP_CYCLES(20), .ERR_OPER_CYCLES(8), .MEAS_CYCLES(6)) dut_u (
    .mclk(mclk), .resetn(resetn), .spiClk(spiClk), .spiSelN(spiSelN), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .enableIn(enableIn), .vinAboveUv(vinAboveUv),
    .dieOverTemp(dieOverTemp), .gateSupplyAtTarget(gateSupplyAtTarget),
    .dieTempCode(dieTempCode), .dimIn(dimIn), .currentReached(currentReached),
    .bootUv(bootUv), .lowHeadroom(lowHeadroom), .switchToggling(switchToggling),
    .gateRegEn(gateRegEn), .gateDriverEn(gateDriverEn), .gateSwitchEn(gateSwitchEn),
    .ledMeasureUpdate(ledMeasureUpdate), .bootRechargeReq(bootRechargeReq),
    .chargeMaintainEn(chargeMaintainEn));
  spi_host_model host_u (.mclk(mclk), .spiMiso(spiMiso), .spiClk(spiClk),
    .spiSelN(spiSelN), .spiMosi(spiMosi));

  always #4 mclk = ~mclk;

  task automatic conclude();
    $display("counts: %0d checked, %0d mismatches", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [6:0] a);
    host_u.xfer(16, {1'b0, a, 8'h00}, rsp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer(16, {1'b1, a, d}, rsp);
  endtask
  task automatic stat(input logic [7:0] exp);
    rd(led_diag_pkg::ADDR_DIAG_ONE);
    check("status", exp, rsp[7:0]);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    conclude();
  end

  initial begin
    wait_n(12);
    resetn = 1'b1;
    wait_n(4);
    stat(8'h00);
    rd(led_diag_pkg::ADDR_FUNC_CTRL);
    check("function control", 8'h86, rsp[7:0]);
    rd(led_diag_pkg::ADDR_DIE_TEMP);
    check("temperature", 8'hD8, rsp[7:0]);
    dieTempCode = 8'hAF;
    rd(led_diag_pkg::ADDR_DIE_TEMP);
    check("temperature", 8'hAF, rsp[7:0]);
    done("reset");
    vinAboveUv = 1'b1;
    wait_n(5);
    stat(8'h88);
    check("gate switching", 8'h03, 8'(gateSwitchEn));
    check("measure update", 8'h01, 8'(ledMeasureUpdate));
    check("driver", 8'h01, 8'(gateDriverEn));
    check("miso enable", 8'h00, 8'(spiMisoOe));
    done("supply");
    wr(led_diag_pkg::ADDR_DIAG_TWO, 8'h00);
    // the 17-clock frame carries an otherwise valid write of zero to function control
    for (int i = 0; i < 3; i++) begin
      host_u.xfer(bad[i][16] ? 16 : 17, bad[i][15:0], rsp);
      rd(led_diag_pkg::ADDR_DIAG_ONE);
      check("status after error", 8'hC8, rsp[15:8]);
      check("error answer", 8'h40, rsp[7:0]);
      check("gate switching", 8'h03, 8'(gateSwitchEn));
      wr(led_diag_pkg::ADDR_DIAG_ONE, 8'h00);
      stat(8'h88);
    end
    done("serial errors");
    dieOverTemp = 1'b1;
    dieTempCode = 8'hB4;
    wait_n(3);
    check("regulator", 8'h00, 8'(gateRegEn));
    stat(8'hB0);
    dieOverTemp = 1'b0;
    wr(led_diag_pkg::ADDR_FUNC_CTRL, 8'h44);
    wait_n(5);
    stat(8'h88);
    rd(led_diag_pkg::ADDR_FUNC_CTRL);
    check("clear request", 8'h84, rsp[7:0]);
    check("gate switching", 8'h02, 8'(gateSwitchEn));
    done("overtemp");
    gateSupplyAtTarget = 1'b0;
    wait_n(12);
    check("regulator", 8'h00, 8'(gateRegEn));
    check("measure update", 8'h00, 8'(ledMeasureUpdate));
    check("gate switching", 8'h00, 8'(gateSwitchEn));
    stat(8'h90);
    enableIn = 1'b0;
    wait_n(3);
    gateSupplyAtTarget = 1'b1;
    enableIn = 1'b1;
    wait_n(5);
    stat(8'h88);
    done("gate fault");
    currentReached = 2'b01;
    wait_n(1);
    currentReached = 2'b00;
    dimIn = 2'b00;
    wait_n(3);
    stat(8'h89);
    currentReached = 2'b10;
    wait_n(1);
    currentReached = 2'b00;
    wr(led_diag_pkg::ADDR_COPY_REQ, 8'h03);
    stat(8'h8A);
    check("maintain", 8'h03, 8'(chargeMaintainEn));
    check("recharge", 8'h03, 8'(bootRechargeReq));
    bootUv = 2'b01;
    lowHeadroom = 2'b10;
    switchToggling = 2'b01;
    wait_n(3);
    check("maintain", 8'h00, 8'(chargeMaintainEn));
    check("recharge", 8'h02, 8'(bootRechargeReq));
    stat(8'h88);
    bootUv = 2'b00;
    lowHeadroom = 2'b00;
    switchToggling = 2'b00;
    done("current hit");
    vinAboveUv = 1'b0;
    gateSupplyAtTarget = 1'b0;
    wait_n(3);
    check("measure update", 8'h00, 8'(ledMeasureUpdate));
    stat(8'h00);
    vinAboveUv = 1'b1;
    wait_n(3);
    check("regulator", 8'h01, 8'(gateRegEn));
    // start-up delay is longer than the running one
    wait_n(9);
    check("regulator", 8'h01, 8'(gateRegEn));
    wait_n(12);
    check("regulator", 8'h00, 8'(gateRegEn));
    done("supply low");
    conclude();
  end
endmodule
`default_nettype wire
